// >>> cpu_move_map.svh
`ifndef CPU_MOVE_MAP_SVH
`define CPU_MOVE_MAP_SVH
// Bank-relative general register numbers
`define REG_X 3'd0
`define REG_A 3'd1
`define REG_C 3'd2
`define REG_B 3'd3
`define REG_E 3'd4
`define REG_D 3'd5
`define REG_L 3'd6
`define REG_H 3'd7
// Register pair numbers, pair n holds registers 2n+1 (high) and 2n (low)
`define PAIR_AX 2'd0
`define PAIR_BC 2'd1
`define PAIR_DE 2'd2
`define PAIR_HL 2'd3
// Operand address spans
`define SADDR_LO 16'hfe20
`define SADDR_HI 16'hff1f
`define SADDR_SPLIT 8'h20
`define SADDR_PAGE 8'hfe
`define SFR_PAGE 8'hff
`define SFR_GAP_LO 16'hffd0
`define SFR_GAP_HI 16'hffdf
`define CALL_LO 16'h0800
`define TABLE_LO 16'h0040
// Status word bit positions and reset value
`define PSW_Z 6
`define PSW_RBS1 5
`define PSW_AC 4
`define PSW_RBS0 3
`define PSW_CY 0
`define PSW_RESET 8'h00
// Clock counts of the transfer group
`define CYC_2 6'd2
`define CYC_4 6'd4
`define CYC_5 6'd5
`define CYC_6 6'd6
`define CYC_7 6'd7
`define CYC_8 6'd8
`define CYC_9 6'd9
`define CYC_10 6'd10
`endif

// >>> cpu_move_pkg.sv
package cpu_move_pkg;
  typedef enum logic [2:0] {
    OP_MOVE, OP_EXCH, OP_CALL, OP_TABLE, OP_REL, OP_WCHK
  } op_t;

  typedef enum logic [3:0] {
    K_REG, K_SADDR, K_SFR, K_ABS, K_PSW,
    K_DE, K_HL, K_HLD, K_HLB, K_HLC
  } kind_t;

  typedef enum logic {S_IDLE, S_EXEC} state_t;

  typedef struct packed {
    op_t         op;
    kind_t       kind;
    logic        to_acc;
    logic        imm;
    logic [2:0]  rsel;
    logic [7:0]  data;
    logic [15:0] addr;
    logic [15:0] pc;
  } req_t;

  typedef struct packed {
    logic        fault;
    logic [5:0]  clocks;
    logic [15:0] target;
  } res_t;
endpackage

// >>> cpu_data_move_operands.sv
`timescale 1ns/1ps
`include "cpu_move_map.svh"

// Overview of operation
// RL1: general registers X,A,C,B,E,D,L,H are 0..7
// RL2: pairs AX,BC,DE,HL are numbers 0..3
// RL3: short direct spans FE20h-FF1Fh, word form even
// RL4: absolute address full range, word form even
// RL5: short call targets lie in 0800h-0FFFh
// RL6: table references hit even 0040h-007Fh only
// RL7: bit 3 bits, byte 8, word 16
// RL8: word special register operand even addresses only
// RL9: special register forms cannot reach FFD0h-FFDFh
// RL10: status word writes set Z, AC, CY
// RL11: short count for fast RAM, else long
// RL12: external reads add read wait states
// RL13: external writes add write waits; exchange both
// RL14: counts assume fetch from internal program ROM
// RL15: A is byte accumulator, AX word accumulator
// RL16: displacement is signed byte added to PC
// RL17: four register banks chosen by bank flags
// RL18: move copies unchanged; exchange swaps atomically
// RL19: accumulator register move 2, immediate 4 clocks
module cpu_data_move_operands
  import cpu_move_pkg::*;
#(
  parameter logic [15:0] HSRAM_LO = 16'hfb00,
  parameter logic [15:0] HSRAM_HI = 16'hfeff,
  parameter logic [15:0] EXT_LO   = 16'h8000,
  parameter logic [15:0] EXT_HI   = 16'hf7ff
) (
  input  wire logic        clk_i,        // 200 MHz core clock
  input  wire logic        rst_i,        // Synchronous reset
  input  wire logic        req_valid_i,  // Decoded instruction valid
  input  wire req_t        req_i,        // Decoded instruction
  input  wire logic [3:0]  rd_waits_i,   // Expansion read waits
  input  wire logic [3:0]  wr_waits_i,   // Expansion write waits
  input  wire logic [7:0]  mem_rdata_i,  // Read data, cycle after rd
  output logic             ready_o,      // Idle, takes a request
  output logic             done_o,       // Instruction finished
  output res_t             res_o,        // Fault, clocks, target
  output logic             mem_rd_o,     // Data read strobe
  output logic             mem_wr_o,     // Data write strobe
  output logic [15:0]      mem_addr_o,   // Data address
  output logic [7:0]       mem_wdata_o,  // Write data
  output logic [7:0]       acc_o,        // Byte accumulator
  output logic [15:0]      wide_acc_o,   // Word accumulator
  output logic [7:0]       psw_o         // Status word
);

  state_t      st_r;
  req_t        cur_r;
  logic [5:0]  cnt_r;
  logic [5:0]  clk_r;
  logic [15:0] tgt_r;
  logic        fault_r;
  logic        wr_r;
  logic        rd_cap_r;
  logic [7:0]  mdata_r;
  logic [7:0]  psw_r;
  logic [7:0]  regs_r [0:31];
  logic        ready_r;
  logic        done_r;
  res_t        res_r;
  logic        mem_rd_r;
  logic        mem_wr_r;
  logic [15:0] mem_addr_r;
  logic [7:0]  mem_wdata_r;
  logic [7:0]  acc_r;
  logic [15:0] wide_r;

  function automatic logic [4:0] ridx(input logic [1:0] b,
                                      input logic [2:0] r);
    return {b, r}; // see RL17
  endfunction

  function automatic logic in_rng(input logic [15:0] a,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // Short direct byte maps FE20h..FEFFh then FF00h..FF1Fh
  function automatic logic [15:0] saddr_of(input logic [7:0] o);
    if (o >= `SADDR_SPLIT) begin
      return {`SADDR_PAGE, o}; // see RL3
    end
    return {`SFR_PAGE, o};
  endfunction

  // Returns {short, long} count of a transfer form
  function automatic logic [11:0] base_cyc(input kind_t k,
                                           input logic x,
                                           input logic im);
    logic [5:0] s;
    logic [5:0] l;
    s = `CYC_4;
    l = `CYC_5;
    case (k)
      K_REG: begin
        s = im ? `CYC_4 : `CYC_2; // see RL19
        l = s;
      end
      K_SADDR: begin
        s = im ? `CYC_6 : `CYC_4;
        l = im ? `CYC_7 : (x ? `CYC_6 : `CYC_5);
      end
      K_SFR: begin
        s = im ? `CYC_7 : (x ? `CYC_6 : `CYC_5);
        l = s;
      end
      K_PSW: begin
        s = im ? `CYC_7 : `CYC_5;
        l = s;
      end
      K_ABS, K_HLD: begin
        s = `CYC_8;
        l = x ? `CYC_10 : `CYC_9;
      end
      K_DE, K_HL: begin
        s = `CYC_4;
        l = x ? `CYC_6 : `CYC_5;
      end
      K_HLB, K_HLC: begin
        s = x ? `CYC_8 : `CYC_6;
        l = x ? `CYC_10 : `CYC_7;
      end
      default: begin
        s = `CYC_2;
        l = `CYC_2;
      end
    endcase
    return {s, l};
  endfunction

  logic [1:0]  bank;
  logic [7:0]  a_now;
  logic [15:0] hl_now;
  logic [15:0] ea_c;
  logic [15:0] tgt_c;
  logic        fault_c;
  logic        memacc_c;
  logic        rd_c;
  logic        wr_c;
  logic [5:0]  clk_c;
  logic [11:0] sl_c;
  logic        xch_c;

  assign bank   = {psw_r[`PSW_RBS1], psw_r[`PSW_RBS0]};
  assign a_now  = regs_r[ridx(bank, `REG_A)]; // see RL15
  assign hl_now = {regs_r[ridx(bank, `REG_H)],
                   regs_r[ridx(bank, `REG_L)]}; // see RL2

  // Decode of the offered request
  // Immediate forms carry the short operand offset in addr[7:0]
  always_comb begin
    xch_c    = (req_i.op == OP_EXCH);
    ea_c     = req_i.addr;
    tgt_c    = 16'h0000;
    fault_c  = 1'b0;
    case (req_i.kind)
      K_SADDR: ea_c = saddr_of(req_i.imm ? req_i.addr[7:0] : req_i.data);
      K_SFR:   ea_c = {`SFR_PAGE, req_i.imm ? req_i.addr[7:0] : req_i.data};
      K_DE:    ea_c = {regs_r[ridx(bank, `REG_D)],
                       regs_r[ridx(bank, `REG_E)]};
      K_HL:    ea_c = hl_now;
      K_HLD:   ea_c = hl_now + {8'h00, req_i.data};
      K_HLB:   ea_c = hl_now + {8'h00, regs_r[ridx(bank, `REG_B)]};
      K_HLC:   ea_c = hl_now + {8'h00, regs_r[ridx(bank, `REG_C)]};
      default: ea_c = req_i.addr;
    endcase
    memacc_c = (req_i.kind != K_REG) && (req_i.kind != K_PSW);
    rd_c = memacc_c && !req_i.imm && (req_i.to_acc || xch_c);
    wr_c = memacc_c && (req_i.imm || !req_i.to_acc || xch_c);
    sl_c = base_cyc(req_i.kind, xch_c, req_i.imm);
    if (!memacc_c || in_rng(ea_c, HSRAM_LO, HSRAM_HI)) begin
      clk_c = sl_c[11:6]; // see RL11
    end else begin
      clk_c = sl_c[5:0]; // see RL11
    end
    if (memacc_c && in_rng(ea_c, EXT_LO, EXT_HI)) begin
      if (rd_c) begin
        clk_c = clk_c + {2'b00, rd_waits_i}; // see RL12
      end
      if (wr_c) begin
        clk_c = clk_c + {2'b00, wr_waits_i}; // see RL13
      end
    end
    case (req_i.op)
      OP_MOVE: begin
        if (req_i.imm) begin
          fault_c = !(req_i.kind inside {K_REG, K_SADDR, K_SFR, K_PSW});
        end
      end
      OP_EXCH: begin
        fault_c = req_i.imm || (req_i.kind == K_PSW) ||
                  (req_i.kind == K_REG && req_i.rsel == `REG_A);
      end
      OP_CALL: begin
        tgt_c = `CALL_LO | {5'd0, req_i.addr[10:0]}; // see RL5
      end
      OP_TABLE: begin
        tgt_c = `TABLE_LO | {10'd0, req_i.addr[4:0], 1'b0}; // see RL6
      end
      OP_REL: begin
        tgt_c = req_i.pc + {{8{req_i.data[7]}}, req_i.data}; // see RL16
      end
      OP_WCHK: begin
        tgt_c = ea_c;
        fault_c = ea_c[0] || // see RL4, RL8
                  !(req_i.kind inside {K_SADDR, K_SFR, K_ABS});
        if (req_i.kind == K_SADDR) begin
          fault_c = fault_c || !in_rng(ea_c, `SADDR_LO, `SADDR_HI); // see RL3
        end
      end
      default: fault_c = 1'b1;
    endcase
    // Special register forms never reach the reserved span
    if (req_i.kind == K_SFR && in_rng(ea_c, `SFR_GAP_LO, `SFR_GAP_HI)) begin
      fault_c = 1'b1; // see RL8, RL9
    end
    // Faulted or non-transfer forms retire in the minimum count
    if (fault_c || !(req_i.op inside {OP_MOVE, OP_EXCH})) begin
      clk_c = `CYC_2;
      rd_c  = 1'b0;
      wr_c  = 1'b0;
    end
  end

  logic take;
  logic last;
  assign take = (st_r == S_IDLE) && req_valid_i;
  assign last = (st_r == S_EXEC) && (cnt_r == 6'd1);

  // Sequencing: the count of cycles from take to done is clk_c
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r    <= S_IDLE;
      cnt_r   <= 6'd0;
      ready_r <= 1'b1;
      done_r  <= 1'b0;
      res_r   <= '0;
      cur_r   <= '0;
      clk_r   <= 6'd0;
      tgt_r   <= 16'h0000;
      fault_r <= 1'b0;
      wr_r    <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        S_IDLE: begin
          if (req_valid_i) begin
            st_r    <= S_EXEC;
            cnt_r   <= clk_c - 6'd1; // see RL14
            ready_r <= 1'b0;
            cur_r   <= req_i;
            clk_r   <= clk_c;
            tgt_r   <= tgt_c;
            fault_r <= fault_c;
            wr_r    <= wr_c;
          end
        end
        S_EXEC: begin
          cnt_r <= cnt_r - 6'd1;
          if (cnt_r == 6'd1) begin
            st_r    <= S_IDLE;
            ready_r <= 1'b1;
            done_r  <= 1'b1;
            res_r   <= '{fault: fault_r, clocks: clk_r, target: tgt_r};
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // Memory port; read data is caught the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_rd_r    <= 1'b0;
      mem_wr_r    <= 1'b0;
      mem_addr_r  <= 16'h0000;
      mem_wdata_r <= 8'h00;
      rd_cap_r    <= 1'b0;
      mdata_r     <= 8'h00;
    end else begin
      mem_rd_r <= take && rd_c;
      rd_cap_r <= mem_rd_r;
      if (rd_cap_r) begin
        mdata_r <= mem_rdata_i;
      end
      if (take) begin
        mem_addr_r <= ea_c;
      end
      // Write goes out in the final cycle, after the read for exchanges
      mem_wr_r <= (st_r == S_EXEC) && (cnt_r == 6'd2) && wr_r &&
                  !fault_r; // see RL13
      if ((st_r == S_EXEC) && (cnt_r == 6'd2)) begin
        mem_wdata_r <= cur_r.imm ? cur_r.data : a_now; // see RL18
      end
    end
  end

  logic data_op;
  assign data_op = last && !fault_r &&
                   (cur_r.op inside {OP_MOVE, OP_EXCH});

  // General registers, committed in one cycle so exchange is atomic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 32; i++) begin
        regs_r[i] <= 8'h00;
      end
    end else if (data_op) begin
      if (cur_r.imm) begin
        if (cur_r.kind == K_REG) begin
          regs_r[ridx(bank, cur_r.rsel)] <= cur_r.data; // see RL7, RL19
        end
      end else if (cur_r.op == OP_EXCH || cur_r.to_acc) begin
        case (cur_r.kind)
          K_REG:   regs_r[ridx(bank, `REG_A)] <=
                     regs_r[ridx(bank, cur_r.rsel)]; // see RL1, RL18
          K_PSW:   regs_r[ridx(bank, `REG_A)] <= psw_r;
          default: regs_r[ridx(bank, `REG_A)] <= mdata_r; // see RL18
        endcase
        if (cur_r.op == OP_EXCH && cur_r.kind == K_REG) begin
          regs_r[ridx(bank, cur_r.rsel)] <= a_now; // see RL18
        end
      end else if (cur_r.kind == K_REG) begin
        regs_r[ridx(bank, cur_r.rsel)] <= a_now; // see RL1
      end
    end
  end

  // Only a status word move touches the flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      psw_r <= `PSW_RESET;
    end else if (data_op && cur_r.op == OP_MOVE &&
                 cur_r.kind == K_PSW && !cur_r.to_acc) begin
      psw_r <= cur_r.imm ? cur_r.data : a_now; // see RL10, RL17
    end
  end

  // Accumulator views lag the register file by one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r  <= 8'h00;
      wide_r <= 16'h0000;
    end else begin
      acc_r  <= a_now; // see RL15
      wide_r <= {a_now, regs_r[ridx(bank, `REG_X)]}; // see RL15
    end
  end

  assign ready_o     = ready_r;
  assign done_o      = done_r;
  assign res_o       = res_r;
  assign mem_rd_o    = mem_rd_r;
  assign mem_wr_o    = mem_wr_r;
  assign mem_addr_o  = mem_addr_r;
  assign mem_wdata_o = mem_wdata_r;
  assign acc_o       = acc_r;
  assign wide_acc_o  = wide_r;
  assign psw_o       = psw_r;

endmodule

// >>> cpu_move_sva.sv
`timescale 1ns/1ps
module cpu_move_sva
  import cpu_move_pkg::*;
(
  input wire logic        clk_i,        // Core clock
  input wire logic        rst_i,        // Synchronous reset
  input wire logic        req_valid_i,  // Request valid
  input wire logic        ready_o,      // Idle
  input wire logic        done_o,       // Finished
  input wire res_t        res_o,        // Result
  input wire logic        mem_rd_o,     // Read strobe
  input wire logic        mem_wr_o,     // Write strobe
  input wire logic [15:0] mem_addr_o,   // Data address
  input wire logic [7:0]  acc_o,        // Byte accumulator
  input wire logic [15:0] wide_acc_o    // Word accumulator
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_take; ready_o && req_valid_i |=> !ready_o; endproperty
  a_take: assert property (p_take) else $error("take left idle");
  property p_pulse; done_o |=> !done_o; endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
  property p_done_rdy; done_o |-> ready_o; endproperty
  a_done_rdy: assert property (p_done_rdy) else $error("done busy");
  property p_min; done_o |-> res_o.clocks >= 6'd2; endproperty
  a_min: assert property (p_min) else $error("count below two");
  property p_rose; $rose(ready_o) |-> done_o; endproperty
  a_rose: assert property (p_rose) else $error("idle without done");
  property p_wr; mem_wr_o |-> !ready_o ##1 done_o; endproperty
  a_wr: assert property (p_wr) else $error("write not last");
  property p_rd; mem_rd_o |-> $past(ready_o && req_valid_i); endproperty
  a_rd: assert property (p_rd) else $error("read not first");
  // Address must stand through the whole instruction
  property p_addr;
    !$past(ready_o && req_valid_i) |-> $stable(mem_addr_o);
  endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_wide; wide_acc_o[15:8] == acc_o; endproperty
  a_wide: assert property (p_wide) else $error("word acc split");
  property p_bound; !ready_o |-> ##[1:40] ready_o; endproperty
  a_bound: assert property (p_bound) else $error("busy too long");
endmodule

bind cpu_data_move_operands cpu_move_sva chk (
  .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
  .ready_o(ready_o), .done_o(done_o), .res_o(res_o),
  .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
  .acc_o(acc_o), .wide_acc_o(wide_acc_o)
);

// >>> cpu_move_mem.sv
`timescale 1ns/1ps
module cpu_move_mem (
  input  wire logic        clk_i,    // Core clock
  input  wire logic        rd_i,     // Read strobe
  input  wire logic        wr_i,     // Write strobe
  input  wire logic [15:0] addr_i,   // Address
  input  wire logic [7:0]  wdata_i,  // Write data
  output logic      [7:0]  rdata_o   // Read data
);
  logic [7:0] mem [logic [15:0]];

  initial rdata_o = 8'h00;
  // Outside the answer cycle the bus toggles so stale data never matches
  always @(posedge clk_i) begin
    if (wr_i)
      mem[addr_i] = wdata_i;
    if (rd_i)
      rdata_o <= mem.exists(addr_i) ? mem[addr_i]
                 : addr_i[7:0] ^ addr_i[15:8] ^ 8'h3c;
    else
      rdata_o <= ~rdata_o;
  end
endmodule

// >>> cpu_data_move_operands_test.sv
`timescale 1ns/1ps
module cpu_data_move_operands_test;
  import cpu_move_pkg::*;
  typedef struct packed {
    res_t        r;
    logic        ct;
    logic [15:0] w;
    logic [7:0]  p;
  } note_t;
  logic        clk_i = 0, rst_i = 1, req_valid_i = 0, pend = 0;
  req_t        req_i = '0;
  logic [3:0]  rd_waits_i = 0, wr_waits_i = 0, nw = 0, mw = 0;
  logic [7:0]  mem_rdata_i, mem_wdata_o, acc_o, psw_o, d, v, ps = 0;
  logic        ready_o, done_o, mem_rd_o, mem_wr_o;
  logic [15:0] mem_addr_o, wide_acc_o, a, pcv = 0;
  res_t        res_o;
  note_t       notes[$], cur;
  logic [7:0]  rf[4][8] = '{default: 8'h00};
  logic [7:0]  shadow[logic [15:0]];
  logic [47:0] pk = 48'hfc10_8120_f002;
  int          n_errors = 0, n_checks = 0, seed = 32'haf9f, cyc = 0, b, i;

  initial forever #2.5 clk_i = ~clk_i;

  cpu_data_move_operands dut (
    .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .rd_waits_i(rd_waits_i), .wr_waits_i(wr_waits_i),
    .mem_rdata_i(mem_rdata_i), .ready_o(ready_o), .done_o(done_o),
    .res_o(res_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .acc_o(acc_o),
    .wide_acc_o(wide_acc_o), .psw_o(psw_o)
  );
  cpu_move_mem mem (
    .clk_i(clk_i), .rd_i(mem_rd_o), .wr_i(mem_wr_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i)
  );

  function logic [1:0] bk();
    return {ps[5], ps[3]};
  endfunction
  function logic [7:0] rdv(input logic [15:0] x);
    return shadow.exists(x) ? shadow[x] : x[7:0] ^ x[15:8] ^ 8'h3c;
  endfunction
  function req_t mk(op_t o, kind_t k, logic ta, logic im, logic [2:0] rs,
                    logic [7:0] dd, logic [15:0] aa);
    return '{op:o, kind:k, to_acc:ta, imm:im, rsel:rs, data:dd, addr:aa,
             pc:pcv};
  endfunction

  task give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk_val(input string s, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  // Target is only compared when the caller sets ct
  task chk_res(input res_t e, input res_t g, input logic ct);
    n_checks++;
    if (g.fault !== e.fault || g.clocks !== e.clocks
        || (ct && g.target !== e.target)) begin
      n_errors++;
      $display("mismatch result expected %h seen %h", e, g);
    end
  endtask
  // Request stays up between calls so back-to-back takes never glitch
  task go(input req_t r, input logic [5:0] cl, input logic [15:0] t,
          input logic f, input logic ct);
    int k;
    req_i <= r;
    req_valid_i <= 1'b1;
    rd_waits_i <= nw;
    wr_waits_i <= mw;
    notes.push_back({f, cl, t, ct, rf[bk()][1], rf[bk()][0], ps});
    for (k = 0; k < 60; k++) begin
      @(posedge clk_i);
      if (ready_o === 1'b1)
        break;
    end
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 5000) begin
      n_errors++;
      give_verdict();
    end
    if (pend) begin
      chk_val("word acc", cur.w, wide_acc_o);
      chk_val("acc", {8'h00, cur.w[15:8]}, {8'h00, acc_o});
      chk_val("flags", {8'h00, cur.p & 8'h79}, {8'h00, psw_o & 8'h79});
    end
    pend <= 1'b0;
    if (done_o === 1'b1) begin
      cur = notes.pop_front();
      chk_res(cur.r, res_o, cur.ct);
      pend <= 1'b1;
    end
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (b = 0; b < 4; b++) begin
      d = $random(seed);
      d[5] = b[1];
      d[3] = b[0];
      ps = d;
      go(mk(OP_MOVE, K_PSW, 0, 1, 0, d, 0), 7, 0, 0, 1);
      for (i = 0; i < 8; i++) begin
        rf[b][i] = $random(seed);
        go(mk(OP_MOVE, K_REG, 0, 1, i[2:0], rf[b][i], 0), 4, 0, 0, 1);
      end
      for (i = 0; i < 8; i++) if (i != 1) begin
        rf[b][1] = rf[b][i];
        go(mk(OP_MOVE, K_REG, 1, 0, i[2:0], 0, 0), 2, 0, 0, 1);
      end
    end
    for (i = 0; i < 2; i++) begin
      a = i ? 16'hff10 : 16'hfe80;
      rf[bk()][1] = rdv(a);
      go(mk(OP_MOVE, K_SADDR, 1, 0, 0, a[7:0], 0), i ? 5 : 4, 0, 0, 1);
    end
    repeat (4) begin
      nw = $random(seed);
      mw = $random(seed);
      a = 16'h8000 + ($random(seed) & 16'h3fff);
      v = rdv(a);
      d = $random(seed);
      rf[bk()][1] = v;
      go(mk(OP_MOVE, K_ABS, 1, 0, 0, 0, a), 9 + nw, 0, 0, 1);
      rf[bk()][1] = d;
      go(mk(OP_MOVE, K_REG, 0, 1, 1, d, 0), 4, 0, 0, 1);
      rf[bk()][1] = v;
      shadow[a] = d;
      go(mk(OP_EXCH, K_ABS, 1, 0, 0, 0, a), 10 + nw + mw, 0, 0, 1);
      rf[bk()][1] = d;
      go(mk(OP_MOVE, K_ABS, 1, 0, 0, 0, a), 9 + nw, 0, 0, 1);
      go(mk(OP_MOVE, K_ABS, 0, 0, 0, 0, a), 9 + mw, 0, 0, 1);
    end
    rf[bk()][1] = rdv(16'hfc00);
    go(mk(OP_MOVE, K_ABS, 1, 0, 0, 0, 16'hfc00), 8, 0, 0, 1);
    rf[bk()][1] = rdv(16'h0100);
    go(mk(OP_MOVE, K_ABS, 1, 0, 0, 0, 16'h0100), 9, 0, 0, 1);
    rf[bk()][1] = rdv(16'hff30);
    go(mk(OP_MOVE, K_SFR, 1, 0, 0, 8'h30, 0), 5, 0, 0, 1);
    go(mk(OP_MOVE, K_SFR, 1, 0, 0, 8'hd5, 0), 2, 0, 1, 0);
    go(mk(OP_EXCH, K_REG, 1, 0, 1, 0, 0), 2, 0, 1, 0);
    for (i = 0; i < 4; i++) begin
      a = $random(seed);
      d = i ? $random(seed) : 8'h80;
      pcv = $random(seed);
      go(mk(OP_CALL, K_REG, 0, 0, 0, 0, a), 2, 16'h0800 | a[10:0], 0, 1);
      go(mk(OP_TABLE, K_REG, 0, 0, 0, 0, a), 2, {a[4:0], 1'b0} | 16'h0040,
         0, 1);
      go(mk(OP_REL, K_REG, 0, 0, 0, d, 0), 2, pcv + {{8{d[7]}}, d}, 0, 1);
      a[0] = i[0];
      go(mk(OP_WCHK, K_ABS, 0, 0, 0, 0, a), 2, a, i[0], 1);
    end
    go(mk(OP_WCHK, K_SFR, 0, 0, 0, 8'hd4, 0), 2, 16'hffd4, 1, 1);
    go(mk(OP_WCHK, K_SFR, 0, 0, 0, 8'h30, 0), 2, 16'hff30, 0, 1);
    go(mk(OP_WCHK, K_SADDR, 0, 0, 0, 8'h21, 0), 2, 16'hfe21, 1, 1);
    shadow[16'hfea0] = 8'h5a;
    go(mk(OP_MOVE, K_SADDR, 0, 1, 0, 8'h5a, 16'ha0), 6, 0, 0, 1);
    rf[bk()][1] = 8'h5a;
    go(mk(OP_MOVE, K_SADDR, 1, 0, 0, 8'ha0, 0), 4, 0, 0, 1);
    // Pointer pairs: HL=FC10h, DE=8120h, B=F0h, C=02h
    for (i = 2; i < 8; i++) begin
      rf[bk()][i] = pk[8*(i-2) +: 8];
      go(mk(OP_MOVE, K_REG, 0, 1, i[2:0], rf[bk()][i], 0), 4, 0, 0, 1);
    end
    rf[bk()][1] = rdv(16'hfc10);
    go(mk(OP_MOVE, K_HL, 1, 0, 0, 0, 0), 4, 0, 0, 1);
    nw = $random(seed);
    rf[bk()][1] = rdv(16'h8120);
    go(mk(OP_MOVE, K_DE, 1, 0, 0, 0, 0), 5 + nw, 0, 0, 1);
    rf[bk()][1] = rdv(16'hfc15);
    go(mk(OP_MOVE, K_HLD, 1, 0, 0, 8'h05, 0), 8, 0, 0, 1);
    rf[bk()][1] = rdv(16'hfd00);
    go(mk(OP_MOVE, K_HLB, 1, 0, 0, 0, 0), 6, 0, 0, 1);
    d = rf[bk()][1];
    rf[bk()][1] = rdv(16'hfc12);
    shadow[16'hfc12] = d;
    go(mk(OP_EXCH, K_HLC, 1, 0, 0, 0, 0), 8, 0, 0, 1);
    rf[bk()][1] = d;
    go(mk(OP_MOVE, K_HLC, 1, 0, 0, 0, 0), 6, 0, 0, 1);
    rf[bk()][1] = 8'h51;
    go(mk(OP_MOVE, K_REG, 0, 1, 1, 8'h51, 0), 4, 0, 0, 1);
    ps = 8'h51;
    go(mk(OP_MOVE, K_PSW, 0, 0, 0, 0, 0), 5, 0, 0, 1);
    rf[bk()][1] = ps;
    go(mk(OP_MOVE, K_PSW, 1, 0, 0, 0, 0), 5, 0, 0, 1);
    req_valid_i <= 1'b0;
    repeat (50) @(posedge clk_i);
    chk_val("pending", 16'h0000, 16'(notes.size()));
    give_verdict();
  end
endmodule
